// ===== acrl_pkg.sv
// Purpose: shared constants for the converter config reset and load link
// Assumes: one 100 MHz clock on both ends, three-wire serial link
// Notes:   How it works list below; word = 4-bit address + 12-bit data
// How it works
// - reset pulse high at least 2 us
// - reset also restarts core, zeroes data outputs
// - registers programmed only over three-wire serial link
// - unused reset pin held low, software load
// - word: top nibble address, low 12 data
// - load order 9,A,B,C,D,E,0,1,F; E=804
// - software load only when no reset pulse
// - below 60 MSPS program loop-off mode serially
package acrl_pkg;

  // clock and reset pulse timing
  localparam int CLK_MHZ        = 100;
  localparam int RST_MIN_NS     = 2000;
  localparam int RST_MIN_CYC    = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 8;
  localparam logic [7:0] RST_LAST_CNT = 8'(RST_MIN_CYC - 1);
  localparam int GAP_CYC        = 8;
  localparam logic [7:0] GAP_LAST_CNT = 8'(GAP_CYC - 1);
  localparam int SCLK_HALF_CYC  = 4;
  localparam logic [7:0] HALF_LAST_CNT = 8'(SCLK_HALF_CYC - 1);

  // serial word layout
  localparam int WORD_W         = 16;
  localparam int DATA_W         = 12;
  localparam int ADDR_W         = 4;
  localparam int ADDR_LSB       = 12;
  localparam int CFG_N          = 16;
  localparam logic [3:0] BIT_LAST = 4'(WORD_W - 1);

  // register addresses on the serial link
  localparam logic [3:0] ADDR_CFG_0 = 4'h0;
  localparam logic [3:0] ADDR_CFG_1 = 4'h1;
  localparam logic [3:0] ADDR_CFG_9 = 4'h9;
  localparam logic [3:0] ADDR_CFG_A = 4'ha;
  localparam logic [3:0] ADDR_CFG_B = 4'hb;
  localparam logic [3:0] ADDR_CFG_C = 4'hc;
  localparam logic [3:0] ADDR_CFG_D = 4'hd;
  localparam logic [3:0] ADDR_CFG_E = 4'he;
  localparam logic [3:0] ADDR_CFG_F = 4'hf;
  localparam logic [15:0] CFG_IMPL_MASK = 16'hfe03;

  // reset values
  localparam logic [11:0] RST_CFG_E   = 12'h804;
  localparam logic [11:0] RST_CFG_DEF = 12'h000;

  // default load sequence
  localparam int LOAD_LEN = 9;
  localparam logic [3:0] LOAD_LAST = 4'(LOAD_LEN - 1);

  // controller registers on the system bus
  localparam logic [31:0] OFF_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFF_WORD   = 32'h0000_0004;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0008;
  localparam int CTRL_HWRST_BIT  = 0;
  localparam int CTRL_SWLOAD_BIT = 1;
  localparam int CTRL_SEND_BIT   = 2;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_RST_BIT    = 1;
  localparam int STAT_LOAD_BIT   = 2;
  localparam int STAT_SENT_BIT   = 3;
  localparam logic [1:0] HRESP_OKAY = 2'b00;

  function automatic logic [11:0] acrl_cfg_reset(input logic [3:0] a);
    acrl_cfg_reset = (a == ADDR_CFG_E) ? RST_CFG_E : RST_CFG_DEF;
  endfunction

  function automatic logic [15:0] acrl_load_word(input logic [3:0] i);
    logic [3:0] a;
    case (i)
      4'h0:    a = ADDR_CFG_9;
      4'h1:    a = ADDR_CFG_A;
      4'h2:    a = ADDR_CFG_B;
      4'h3:    a = ADDR_CFG_C;
      4'h4:    a = ADDR_CFG_D;
      4'h5:    a = ADDR_CFG_E;
      4'h6:    a = ADDR_CFG_0;
      4'h7:    a = ADDR_CFG_1;
      default: a = ADDR_CFG_F;
    endcase
    acrl_load_word = {a, acrl_cfg_reset(a)};
  endfunction

endpackage

// ===== acrl_link_if.sv
// Purpose: pins between controller and converter config logic
// Assumes: both ends on the same clock net in the bench
// Notes:   all pins one-way, no tristate
`timescale 1ns/10ps
interface acrl_link_if import acrl_pkg::*;;
  logic              rst_pin;
  logic              sclk;
  logic              sen_n;
  logic              sdata;
  logic [DATA_W-1:0] dout;
  logic              dout_vld;

  modport dev (input rst_pin, sclk, sen_n, sdata, output dout, dout_vld);
  modport ctl (output rst_pin, sclk, sen_n, sdata, input dout, dout_vld);
endinterface

// ===== acrl_dev.sv
// Purpose: converter side: serial config registers and reset handling
// Assumes: link pins asynchronous, sampled through three flops
// Notes:   data sampled on rising sclk while sen_n low, msb first
`timescale 1ns/10ps
module acrl_dev import acrl_pkg::*; (
  input  wire logic                         CLK_I,
  input  wire logic                         RESET_N_I,
  acrl_link_if.dev                          LINK,
  input  wire logic [DATA_W-1:0]            SAMPLE_I,
  input  wire logic                         SAMPLE_VALID_I,
  output logic      [CFG_N-1:0][DATA_W-1:0] CFG_O,
  output logic                              CORE_INIT_O
);
  localparam int P_RST  = 3;
  localparam int P_SCLK = 2;
  localparam int P_SEN  = 1;
  localparam int P_SDAT = 0;

  logic [3:0]        s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
  logic              sclk_prev_ff, rst_prev_ff;
  logic [WORD_W-2:0] sh_ff;
  logic [4:0]        cnt_ff;
  logic              sclk_rise, commit;
  logic [WORD_W-1:0] word;
  logic [ADDR_W-1:0] waddr;

  // three-flop pin capture; first flop feeds only the second
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_ff <= 4'h2;
      s2_ff <= 4'h2;
      s3_ff <= 4'h2;
    end else begin
      s1_ff <= {LINK.rst_pin, LINK.sclk, LINK.sen_n, LINK.sdata};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a pin level only moves once flops two and three agree
  assign nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lvl_ff       <= 4'h2;
      sclk_prev_ff <= 1'b0;
      rst_prev_ff  <= 1'b0;
    end else begin
      lvl_ff       <= nxt_lvl;
      sclk_prev_ff <= lvl_ff[P_SCLK];
      rst_prev_ff  <= lvl_ff[P_RST];
    end
  end

  assign sclk_rise = lvl_ff[P_SCLK] & ~sclk_prev_ff;
  assign commit    = sclk_rise & ~lvl_ff[P_SEN] & (cnt_ff == 5'(BIT_LAST));
  assign word      = {sh_ff, lvl_ff[P_SDAT]};
  assign waddr     = word[WORD_W-1:ADDR_LSB];

  // serial shifter; bits past the sixteenth are ignored until sen_n rises
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sh_ff  <= '0;
      cnt_ff <= '0;
    end else if (lvl_ff[P_RST] || lvl_ff[P_SEN]) begin
      cnt_ff <= '0;
    end else if (sclk_rise && cnt_ff <= 5'(BIT_LAST)) begin
      sh_ff  <= word[WORD_W-2:0];
      cnt_ff <= cnt_ff + 5'd1;
    end
  end

  // config registers; reset pin returns defaults, held while high
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < CFG_N; i++) begin
        CFG_O[i] <= acrl_cfg_reset(4'(i));
      end
    end else if (lvl_ff[P_RST]) begin
      for (int i = 0; i < CFG_N; i++) begin
        CFG_O[i] <= acrl_cfg_reset(4'(i));
      end
    end else if (commit && CFG_IMPL_MASK[waddr]) begin
      CFG_O[waddr] <= word[DATA_W-1:0];
    end
  end

  // core restart and forced-low outputs around the reset pulse
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LINK.dout     <= '0;
      LINK.dout_vld <= 1'b0;
      CORE_INIT_O   <= 1'b0;
    end else begin
      CORE_INIT_O <= rst_prev_ff & ~lvl_ff[P_RST];
      if (lvl_ff[P_RST]) begin
        LINK.dout     <= '0;
        LINK.dout_vld <= 1'b0;
      end else begin
        LINK.dout_vld <= SAMPLE_VALID_I;
        if (SAMPLE_VALID_I) begin
          LINK.dout <= SAMPLE_I;
        end
      end
    end
  end
endmodule

// ===== acrl_ctl.sv
// Purpose: controller: reset pulse, default load and single word writes
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   commands written to ctrl are ignored while busy
`timescale 1ns/10ps
module acrl_ctl import acrl_pkg::*; (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic      [1:0]  HRESP_O,
  acrl_link_if.ctl         LINK
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RST  = 5'b00010,
    S_GAP  = 5'b00100,
    S_SEND = 5'b01000,
    S_NEXT = 5'b10000
  } acrl_state_e;

  acrl_state_e       state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [3:0]        bit_ff;
  logic [3:0]        idx_ff;
  logic              load_mode_ff;
  logic              ap_vld_ff;
  logic              ap_wr_ff;
  logic [31:0]       ap_addr_ff;
  logic [WORD_W-1:0] word_ff;
  logic [WORD_W-1:0] sh_ff;
  logic              sclk_ff;
  logic              rst_done_ff;
  logic              load_done_ff;
  logic              sent_ff;
  logic [31:0]       rd_val;
  logic [WORD_W-1:0] nxt_word;
  logic              wr_ctrl;
  logic              idle;
  logic              go_hw;
  logic              go_load;
  logic              go_one;
  logic              tick;
  logic              last_bit;
  logic              gap_end;
  logic              more;
  logic              start_send;

  // zero-wait slave, always okay; size is not checked, words only
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = HRESP_OKAY;

  // address phase capture
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ap_vld_ff  <= 1'b0;
      ap_wr_ff   <= 1'b0;
      ap_addr_ff <= '0;
    end else if (HREADY_I) begin
      ap_vld_ff  <= HSEL_I & HTRANS_I[1];
      ap_wr_ff   <= HWRITE_I;
      ap_addr_ff <= HADDR_I;
    end
  end

  // read mux; unmapped offsets and ctrl read as zero
  always_comb begin
    rd_val = '0;
    if (HADDR_I == OFF_WORD) begin
      rd_val[WORD_W-1:0] = word_ff;
      // back-to-back write then read: pending word data wins
      if (ap_vld_ff && ap_wr_ff && ap_addr_ff == OFF_WORD) begin
        rd_val[WORD_W-1:0] = HWDATA_I[WORD_W-1:0];
      end
    end else if (HADDR_I == OFF_STATUS) begin
      rd_val[STAT_BUSY_BIT] = ~idle;
      rd_val[STAT_RST_BIT]  = rst_done_ff;
      rd_val[STAT_LOAD_BIT] = load_done_ff;
      rd_val[STAT_SENT_BIT] = sent_ff;
    end
  end

  // read data is fixed at the address phase edge
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      HRDATA_O <= '0;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      HRDATA_O <= rd_val;
    end
  end

  // word register for single writes
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      word_ff <= '0;
    end else if (ap_vld_ff && ap_wr_ff && ap_addr_ff == OFF_WORD) begin
      word_ff <= HWDATA_I[WORD_W-1:0];
    end
  end

  // command decode; hardware reset beats load beats single write
  assign wr_ctrl  = ap_vld_ff & ap_wr_ff & (ap_addr_ff == OFF_CTRL);
  assign idle     = (state_ff == S_IDLE);
  assign go_hw    = idle & wr_ctrl & HWDATA_I[CTRL_HWRST_BIT];
  assign go_load  = idle & wr_ctrl & ~HWDATA_I[CTRL_HWRST_BIT]
                    & HWDATA_I[CTRL_SWLOAD_BIT];
  assign go_one   = idle & wr_ctrl & ~HWDATA_I[CTRL_HWRST_BIT]
                    & ~HWDATA_I[CTRL_SWLOAD_BIT]
                    & HWDATA_I[CTRL_SEND_BIT];
  assign tick     = (state_ff == S_SEND) & (cnt_ff == HALF_LAST_CNT);
  assign last_bit = tick & sclk_ff & (bit_ff == BIT_LAST);
  assign gap_end  = (state_ff == S_NEXT) & (cnt_ff == GAP_LAST_CNT);
  assign more     = load_mode_ff & (idx_ff != LOAD_LAST);
  assign start_send = go_load | go_one | (gap_end & more);

  // word for the frame about to start
  always_comb begin
    nxt_word = word_ff;
    if (go_load) begin
      nxt_word = acrl_load_word(4'h0);
    end else if (gap_end) begin
      nxt_word = acrl_load_word(idx_ff + 4'h1);
    end
  end

  // sequencer
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= '0;
      bit_ff       <= '0;
      idx_ff       <= '0;
      load_mode_ff <= 1'b0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          cnt_ff <= '0;
          bit_ff <= '0;
          if (go_hw) begin
            state_ff <= S_RST;
          end else if (go_load || go_one) begin
            idx_ff       <= '0;
            load_mode_ff <= go_load;
            state_ff     <= S_SEND;
          end
        end
        S_RST: begin
          cnt_ff <= cnt_ff + 8'd1;
          if (cnt_ff == RST_LAST_CNT) begin
            cnt_ff   <= '0;
            state_ff <= S_GAP;
          end
        end
        S_GAP: begin
          cnt_ff <= cnt_ff + 8'd1;
          if (cnt_ff == GAP_LAST_CNT) begin
            state_ff <= S_IDLE;
          end
        end
        S_SEND: begin
          cnt_ff <= tick ? '0 : cnt_ff + 8'd1;
          if (last_bit) begin
            state_ff <= S_NEXT;
          end else if (tick && sclk_ff) begin
            bit_ff <= bit_ff + 4'h1;
          end
        end
        S_NEXT: begin
          cnt_ff <= cnt_ff + 8'd1;
          if (gap_end) begin
            cnt_ff <= '0;
            bit_ff <= '0;
            if (more) begin
              idx_ff   <= idx_ff + 4'h1;
              state_ff <= S_SEND;
            end else begin
              state_ff <= S_IDLE;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // reset pin: high exactly the minimum pulse, low otherwise
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LINK.rst_pin <= 1'b0;
    end else if (go_hw) begin
      LINK.rst_pin <= 1'b1;
    end else if (state_ff == S_RST && cnt_ff == RST_LAST_CNT) begin
      LINK.rst_pin <= 1'b0;
    end
  end

  // serial pins; data moves on falling sclk, far end samples rising
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sclk_ff    <= 1'b0;
      sh_ff      <= '0;
      LINK.sen_n <= 1'b1;
      LINK.sdata <= 1'b0;
    end else if (start_send) begin
      sclk_ff    <= 1'b0;
      sh_ff      <= nxt_word;
      LINK.sen_n <= 1'b0;
      LINK.sdata <= nxt_word[WORD_W-1];
    end else if (last_bit) begin
      sclk_ff    <= 1'b0;
      LINK.sen_n <= 1'b1;
      LINK.sdata <= 1'b0;
    end else if (tick) begin
      sclk_ff <= ~sclk_ff;
      if (sclk_ff) begin
        sh_ff      <= {sh_ff[WORD_W-2:0], 1'b0};
        LINK.sdata <= sh_ff[WORD_W-2];
      end
    end
  end

  assign LINK.sclk = sclk_ff;

  // completion flags; each cleared only when the next command starts
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_done_ff  <= 1'b0;
      load_done_ff <= 1'b0;
      sent_ff      <= 1'b0;
    end else begin
      if (go_hw || go_load || go_one) begin
        rst_done_ff  <= 1'b0;
        load_done_ff <= 1'b0;
        sent_ff      <= 1'b0;
      end
      if (state_ff == S_GAP && cnt_ff == GAP_LAST_CNT) begin
        rst_done_ff <= 1'b1;
      end
      if (gap_end && !more) begin
        load_done_ff <= load_mode_ff;
        sent_ff      <= ~load_mode_ff;
      end
    end
  end
endmodule

// ===== acrl_link_sva.sv
// Purpose: link protocol checks between the controller and converter ends
// Assumes: one clock, RESET_N_I asynchronous and active low
// Notes:   sees the interface signals only, placed beside the interface
`timescale 1ns/10ps
module acrl_link_sva import acrl_pkg::*; (
  input wire logic              CLK_I,
  input wire logic              RESET_N_I,
  input wire logic              rst_pin,
  input wire logic              sclk,
  input wire logic              sen_n,
  input wire logic              sdata,
  input wire logic [DATA_W-1:0] dout,
  input wire logic              dout_vld
);
  logic [7:0] rst_len_ff;
  logic [4:0] rise_cnt_ff;
  logic       sclk_q_ff;

  default clocking chk_cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // high time of the reset pulse, saturating so long pulses stay legal
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) rst_len_ff <= 8'h00;
    else if (!rst_pin) rst_len_ff <= 8'h00;
    else if (rst_len_ff != 8'hff) rst_len_ff <= rst_len_ff + 8'h01;
  end

  // last sclk level, for edge detection
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) sclk_q_ff <= 1'b0;
    else sclk_q_ff <= sclk;
  end

  // sclk rises inside one frame, cleared while the frame is closed
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) rise_cnt_ff <= 5'h00;
    else if (sen_n) rise_cnt_ff <= 5'h00;
    else if (sclk && !sclk_q_ff) rise_cnt_ff <= rise_cnt_ff + 5'h01;
  end

  // one serial clock high phase followed by its fall
  sequence high_phase_s;
    sclk [*4] ##1 !sclk;
  endsequence

  // quiet time on the link after a frame or a reset pulse
  sequence idle_gap_s;
    sen_n [*8];
  endsequence

  pulse_len_a: assert property (
    $fell(rst_pin) |-> rst_len_ff >= 8'(RST_MIN_CYC))
    else $error("reset pulse shorter than the minimum");
  rst_out_low_a: assert property (
    rst_pin [*8] |-> dout == '0 && !dout_vld)
    else $error("data outputs not low during reset pulse");
  rst_quiet_a: assert property (
    rst_pin |-> sen_n)
    else $error("frame open while reset pulse high");
  rst_gap_a: assert property (
    $fell(rst_pin) |-> idle_gap_s)
    else $error("frame opened too soon after reset pulse");
  sclk_high_a: assert property (
    $rose(sclk) |-> high_phase_s)
    else $error("serial clock high phase has wrong length");
  sclk_low_a: assert property (
    $fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  idle_sclk_a: assert property (
    sen_n && $past(sen_n) |-> !sclk)
    else $error("serial clock moves outside a frame");
  data_hold_a: assert property (
    sclk && $past(sclk) |-> $stable(sdata))
    else $error("serial data changed while clock high");
  frame_bits_a: assert property (
    $rose(sen_n) |-> rise_cnt_ff == 5'h10)
    else $error("frame does not carry sixteen bits");
  frame_gap_a: assert property (
    $rose(sen_n) |-> idle_gap_s)
    else $error("frames closer than the idle gap");
endmodule

// ===== adc_config_reset_and_default_load_tb.sv
// Purpose: drives the controller over the bus and checks the converter end
// Assumes: both ends share one 100 MHz clock and one reset
// Notes:   serial words rebuilt from the wire to check order and content
`timescale 1ns/10ps
module adc_config_reset_and_default_load_tb import acrl_pkg::*;;
  logic                         clk_i;
  logic                         reset_n_i;
  logic                         hsel;
  logic                         hwrite;
  logic                         hready;
  logic [1:0]                   htrans;
  logic [2:0]                   hsize;
  logic [1:0]                   hresp;
  logic [31:0]                  haddr;
  logic [31:0]                  hwdata;
  logic [31:0]                  hrdata;
  logic [31:0]                  rd;
  logic [DATA_W-1:0]            sample;
  logic                         sample_vld;
  logic                         core_init;
  logic [CFG_N-1:0][DATA_W-1:0] cfg;
  logic [DATA_W-1:0]            exp_cfg [CFG_N];
  logic [15:0]                  frames [$];
  logic [15:0]                  shift;
  logic [15:0]                  w;
  logic                         sclk_q;
  logic                         sen_q;
  int                           mismatches;
  int                           comparisons;
  int                           cyc;
  int                           rst_hi;
  int                           inits;
  // address order of the default load, first entry in the top nibble
  localparam logic [35:0] ORD = 36'h9abcde01f;

  acrl_link_if acrl_link_if_inst ();
  acrl_ctl acrl_ctl_inst (.CLK_I(clk_i), .RESET_N_I(reset_n_i),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .LINK(acrl_link_if_inst.ctl));
  acrl_dev acrl_dev_inst (.CLK_I(clk_i), .RESET_N_I(reset_n_i),
    .LINK(acrl_link_if_inst.dev), .SAMPLE_I(sample),
    .SAMPLE_VALID_I(sample_vld), .CFG_O(cfg), .CORE_INIT_O(core_init));
  acrl_link_sva acrl_link_sva_inst (.CLK_I(clk_i), .RESET_N_I(reset_n_i),
    .rst_pin(acrl_link_if_inst.rst_pin), .sclk(acrl_link_if_inst.sclk),
    .sen_n(acrl_link_if_inst.sen_n), .sdata(acrl_link_if_inst.sdata),
    .dout(acrl_link_if_inst.dout), .dout_vld(acrl_link_if_inst.dout_vld));

  always #5 clk_i = ~clk_i;

  // samples keep flowing so the output path is busy during reset pulses
  always @(posedge clk_i) begin
    sample     <= DATA_W'($urandom);
    sample_vld <= 1'($urandom);
  end

  // rebuild serial words msb first; count reset time and core restarts
  always @(posedge clk_i) begin
    sclk_q <= acrl_link_if_inst.sclk;
    sen_q  <= acrl_link_if_inst.sen_n;
    if (!acrl_link_if_inst.sen_n && acrl_link_if_inst.sclk && !sclk_q)
      shift <= {shift[14:0], acrl_link_if_inst.sdata};
    if (reset_n_i && acrl_link_if_inst.sen_n && !sen_q) frames.push_back(shift);
    if (acrl_link_if_inst.rst_pin === 1'b1) rst_hi++;
    if (core_init === 1'b1) inits++;
  end

  // a hang ends the run as a failure
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one single transfer: address phase, then data phase, read data in rd
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge clk_i);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    hsize  <= 3'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask

  // poll the busy flag; the cycle limit above bounds a stuck controller
  task automatic wait_idle();
    do ahb(1'b0, OFF_STATUS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask

  function automatic logic [11:0] dflt(input logic [3:0] a);
    return (a == ADDR_CFG_E) ? RST_CFG_E : RST_CFG_DEF;
  endfunction

  function automatic void set_dflt();
    for (int i = 0; i < CFG_N; i++) exp_cfg[i] = dflt(4'(i));
  endfunction

  task automatic chk_cfg();
    for (int i = 0; i < CFG_N; i++) begin
      chk({20'h0, cfg[i]}, {20'h0, exp_cfg[i]});
    end
  endtask

  // one word over the link; addresses 2..8 hold no register
  task automatic send(input logic [15:0] v);
    ahb(1'b1, OFF_WORD, {16'h0, v});
    ahb(1'b1, OFF_CTRL, 32'h1 << CTRL_SEND_BIT);
    wait_idle();
    if (v[15:12] < 4'h2 || v[15:12] > 4'h8) exp_cfg[v[15:12]] = v[11:0];
    chk({16'h0, frames[$]}, {16'h0, v});
    chk(rd, 32'h1 << STAT_SENT_BIT);
    chk_cfg();
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {clk_i, reset_n_i, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {sample, sample_vld, sclk_q, shift, cyc, rst_hi, inits} = '0;
    {hsel, sen_q} = 2'b11;
    mismatches = 0;
    comparisons = 0;
    w = 16'($urandom(67845));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    set_dflt();
    chk_cfg();
    // bus map: word reads back, control and unmapped places read zero
    ahb(1'b1, OFF_WORD, {16'h0, w});
    ahb(1'b0, OFF_WORD, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, w});
    ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    // corner words first, then six random ones at any of the sixteen addresses
    send(16'h2fff);
    send(16'h0fff);
    send(16'hf001);
    repeat (6) send(16'($urandom));
    // reset pulse, with a send issued while busy that must be dropped
    frames.delete();
    rst_hi = 0;
    inits = 0;
    ahb(1'b1, OFF_WORD, 32'h0000_1abc);
    ahb(1'b1, OFF_CTRL, 32'h1 << CTRL_HWRST_BIT);
    ahb(1'b1, OFF_CTRL, 32'h1 << CTRL_SEND_BIT);
    wait_idle();
    chk(rd, 32'h1 << STAT_RST_BIT);
    chk(32'(rst_hi >= RST_MIN_CYC), 32'h1);
    chk(32'(frames.size()), 32'h0);
    chk(32'(inits), 32'h1);
    set_dflt();
    chk_cfg();
    // software default load over dirtied registers
    send(16'he123);
    send(16'h9fff);
    frames.delete();
    ahb(1'b1, OFF_CTRL, 32'h1 << CTRL_SWLOAD_BIT);
    wait_idle();
    chk(rd, 32'h1 << STAT_LOAD_BIT);
    chk(32'(frames.size()), 32'h9);
    for (int i = 0; i < LOAD_LEN; i++) begin
      w = {ORD[35-4*i -: 4], dflt(ORD[35-4*i -: 4])};
      chk({16'h0, frames[i]}, {16'h0, w});
    end
    set_dflt();
    chk_cfg();
    // system reset in the middle of a load, then normal traffic again
    send(16'hd5a5);
    ahb(1'b1, OFF_CTRL, 32'h1 << CTRL_SWLOAD_BIT);
    repeat (60) @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, acrl_link_if_inst.sen_n}, 32'h1);
    chk({31'h0, acrl_link_if_inst.sclk}, 32'h0);
    set_dflt();
    chk_cfg();
    reset_n_i <= 1'b1;
    frames.delete();
    send(16'h1234);
    give_verdict();
  end
endmodule
